/* ecsb_pkg.sv */
// Package for the external memory chip-select bus controller
package ecsb_pkg;

  // ------------------------------------------------------------------
  // Strobe numbering and counts
  // ------------------------------------------------------------------
  localparam int          ECSB_NUM_SEL   = 6;
  localparam logic [2:0]  ECSB_SEL_H1    = 3'h0;
  localparam logic [2:0]  ECSB_SEL_H2    = 3'h1;
  localparam logic [2:0]  ECSB_SEL_H3    = 3'h2;
  localparam logic [2:0]  ECSB_SEL_E1    = 3'h3;
  localparam logic [2:0]  ECSB_SEL_E2    = 3'h4;
  localparam logic [2:0]  ECSB_SEL_PF    = 3'h5;
  localparam logic [2:0]  ECSB_SEL_EDS   = 3'h7;

  // ------------------------------------------------------------------
  // Timing: strobe low two system cycles, write data held two more
  // ------------------------------------------------------------------
  localparam int          ECSB_CLK_MHZ     = 100;
  localparam int          ECSB_STROBE_NS   = 20;
  localparam int          ECSB_HOLD_NS     = 20;
  localparam int          ECSB_STROBE_CYC  =
    (ECSB_STROBE_NS * ECSB_CLK_MHZ + 999) / 1000;
  localparam int          ECSB_HOLD_CYC    =
    (ECSB_HOLD_NS * ECSB_CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  ECSB_STROBE_CNT  = 8'(ECSB_STROBE_CYC);
  localparam logic [7:0]  ECSB_HOLD_CNT    = 8'(ECSB_HOLD_CYC);
  localparam logic [7:0]  ECSB_CNT_ZERO    = 8'h00;
  localparam logic [7:0]  ECSB_CNT_ONE     = 8'h01;
  localparam logic [5:0]  ECSB_ALL_HIGH    = 6'h3F;
  localparam logic [5:0]  ECSB_ALL_LOW     = 6'h00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ECSB_IDLE   = 4'h1,
    ECSB_STROBE = 4'h2,
    ECSB_HOLD   = 4'h4,
    ECSB_DONE   = 4'h8
  } ecsb_state_e;

  typedef struct packed {
    logic        write;
    logic [2:0]  sel;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ecsb_req_s;

  typedef struct packed {
    logic [5:0] select_n;
    logic [5:0] select_oe_n;
    logic       data_strobe_n;
    logic       rw_n;
    logic [15:0] addr;
    logic [7:0] data_out;
    logic       data_oe_n;
  } ecsb_pins_s;

endpackage

/* ecsb_controller.sv */
// Chip-select bus controller: strobes, write hold and pin configuration
// Bus rules; R7 is kept by the attached memories, not by this block
// R1 - Each cycle qualified by one low strobe
// R2 - Strobe rising edge ends transfer, read captured
// R3 - Write data held after strobe rises
// R4 - Only one bank strobe per cycle
// R5 - Chip selects only in microcomputer mode
// R6 - After reset, strobes idle until configured; the code drives a strobe on the first accepted request, configured or not
// R7 - Attached memories release bus when deselected
// R8 - Select pins float as inputs after reset
// R9 - Output switch drives inactive high first
`timescale 1ns/100ps
module ecsb_controller (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   microcomputer_mode,
  input  wire logic [5:0]             select_output_en,
  input  wire logic                   req_valid,
  input  wire ecsb_pkg::ecsb_req_s    req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [7:0]                  rsp_rdata,
  input  wire logic [7:0]             data_in,
  output ecsb_pkg::ecsb_pins_s        pins
);
  import ecsb_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    ecsb_state_e state;
    logic [7:0]  count;
    ecsb_req_s   cur;
    logic        req_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_rdata;
    ecsb_pins_s  pins;
    logic [5:0]  cfg_out;
  } ecsb_regs_s;

  ecsb_regs_s r;
  ecsb_regs_s next_r;

  // Accept edge to the first edge that sees the response: the strobe
  // count, the hold count, the done state and the response register
  localparam int ECSB_RSP_LAT = ECSB_STROBE_CYC + ECSB_HOLD_CYC + 2;

  // One-hot low strobe for a bank, all high for data-strobe cycles
  function automatic logic [5:0] ecsb_decode(input logic [2:0] sel);
    logic [5:0] v;
    v = ECSB_ALL_HIGH;
    if (sel < 3'(ECSB_NUM_SEL)) begin
      v[sel] = 1'b0;
    end
    return v;
  endfunction

  // Bank strobe requests fall back to the data strobe outside
  // microcomputer mode, since those pins do not exist then
  function automatic logic ecsb_use_bank(input logic [2:0] sel,
                                         input logic mc);
    return mc && (sel < 3'(ECSB_NUM_SEL));
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    // Pin direction follows software only in microcomputer mode
    next_r.cfg_out = microcomputer_mode ? select_output_en : ECSB_ALL_LOW;
    case (r.state)
      ECSB_IDLE: begin
        next_r.pins.select_n      = ECSB_ALL_HIGH;  // R9 R6
        next_r.pins.data_strobe_n = 1'b1;
        next_r.pins.data_oe_n     = 1'b1;
        next_r.req_ready          = 1'b1;
        if (req_valid && r.req_ready) begin
          next_r.cur        = req;
          next_r.req_ready  = 1'b0;
          next_r.count      = ECSB_STROBE_CNT;
          next_r.state      = ECSB_STROBE;
          next_r.pins.addr  = req.addr;
          next_r.pins.rw_n  = ~req.write;
          next_r.pins.data_out  = req.wdata;
          next_r.pins.data_oe_n = ~req.write;
          // Exactly one strobe goes low for the cycle
          if (ecsb_use_bank(req.sel, microcomputer_mode)) begin
            next_r.pins.select_n = ecsb_decode(req.sel);  // R4 R1
          end else begin
            next_r.pins.data_strobe_n = 1'b0;  // R1 R5
          end
        end
      end
      ECSB_STROBE: begin
        next_r.count = r.count - ECSB_CNT_ONE;
        if (r.count == ECSB_CNT_ONE) begin
          // Rising strobe ends transfer; read data sampled here
          next_r.pins.select_n      = ECSB_ALL_HIGH;  // R2
          next_r.pins.data_strobe_n = 1'b1;
          next_r.rsp_rdata = r.cur.write ? r.rsp_rdata : data_in;  // R2
          next_r.count     = ECSB_HOLD_CNT;
          next_r.state     = ECSB_HOLD;
        end
      end
      ECSB_HOLD: begin
        // Write data and address stay after the strobe rises
        next_r.count = r.count - ECSB_CNT_ONE;  // R3
        if (r.count == ECSB_CNT_ONE) begin
          next_r.pins.data_oe_n = 1'b1;
          next_r.state          = ECSB_DONE;
        end
      end
      ECSB_DONE: begin
        next_r.rsp_valid = 1'b1;
        next_r.req_ready = 1'b1;
        next_r.state     = ECSB_IDLE;
      end
      default: begin
        next_r.state = ECSB_IDLE;
      end
    endcase
    // Pins stay inputs until configured. A pin about to become an
    // output waits while its own strobe is low, so the first level it
    // ever drives is the inactive high one; otherwise a bank would see
    // a short false select while software sets up the pins.
    // Pins that are already driven stay driven while still configured.
    next_r.pins.select_oe_n = ~r.cfg_out |
      (r.pins.select_oe_n & ~next_r.pins.select_n);  // R8 R5 R9
  end

  // ------------------------------------------------------------------
  // Registers; reset releases the select pins and data bus, all strobes inactive
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.state <= ECSB_IDLE;
      r.pins.select_n <= ECSB_ALL_HIGH;  // R6
      r.pins.select_oe_n <= ECSB_ALL_HIGH;  // R8
      r.pins.data_strobe_n <= 1'b1;
      r.pins.rw_n <= 1'b1;
      r.pins.data_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign req_ready = r.req_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rsp_rdata;
  assign pins      = r.pins;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_one_strobe;
    @(posedge clock) disable iff (reset)
    $countones(~{pins.select_n, pins.data_strobe_n}) <= 1;
  endproperty
  a_one_strobe: assert property (p_one_strobe)  // R4
    else $error("More than one strobe low");

  property p_accept_strobes;
    @(posedge clock) disable iff (reset)
    (req_valid && req_ready) |=>
      ($countones(~{pins.select_n, pins.data_strobe_n}) == 1);
  endproperty
  a_accept_strobes: assert property (p_accept_strobes)  // R1
    else $error("Accepted request did not assert a strobe");

  // A bank request outside the mode must come out on the data strobe
  property p_no_bank_in_mp;
    @(posedge clock) disable iff (reset)
    (req_valid && req_ready && !microcomputer_mode) |=>
      (pins.select_n == ECSB_ALL_HIGH) && !pins.data_strobe_n;
  endproperty
  a_no_bank_in_mp: assert property (p_no_bank_in_mp)  // R5
    else $error("Bank strobe low in microprocessor mode");

  property p_write_hold;
    @(posedge clock) disable iff (reset)
    (!pins.data_oe_n && $rose(pins.data_strobe_n & (&pins.select_n)))
      |-> !pins.data_oe_n && $stable(pins.data_out);
  endproperty
  a_write_hold: assert property (p_write_hold)  // R3
    else $error("Write data dropped at strobe rise");

  property p_end_response;
    @(posedge clock) disable iff (reset)
    (req_valid && req_ready) |-> ##ECSB_RSP_LAT rsp_valid;
  endproperty
  a_end_response: assert property (p_end_response)  // R2
    else $error("Response not at the fixed latency after accept");

  property p_oe_follows_cfg;
    @(posedge clock) disable iff (reset)
    !$past(microcomputer_mode) |=> (pins.select_oe_n == ECSB_ALL_HIGH);
  endproperty
  a_oe_follows_cfg: assert property (p_oe_follows_cfg)  // R8
    else $error("Select pin driven without configuration");

  // Every pin that has just turned into an output shows high
  property p_high_first;
    @(posedge clock) disable iff (reset)
    (($past(pins.select_oe_n) & ~pins.select_oe_n & ~pins.select_n)
      == ECSB_ALL_LOW);
  endproperty
  a_high_first: assert property (p_high_first)  // R9
    else $error("Select pin enabled while low");

  property p_idle_high;
    @(posedge clock) disable iff (reset)
    (req_ready && !rsp_valid && $past(req_ready)) |->
      (pins.select_n == ECSB_ALL_HIGH) && pins.data_strobe_n;
  endproperty
  a_idle_high: assert property (p_idle_high)  // R6
    else $error("Strobe low while idle");

endmodule

/* ecsb_memory_model.sv */
// Memory banks on the shared data bus behind the strobes
`timescale 1ns/100ps
module ecsb_memory_model (
  input  wire logic                 clock,
  input  wire ecsb_pkg::ecsb_pins_s pins,
  output logic [7:0]                data_in
);
  import ecsb_pkg::*;
  logic [7:0] mem [0:6][0:15];
  logic [6:0] sel_n;
  logic [6:0] prev_sel_n = 7'h7F;
  logic [7:0] last = 8'h00;
  // Floating select pins read high through the board pull-ups
  assign sel_n = {pins.data_strobe_n, pins.select_n | pins.select_oe_n};
  initial begin
    for (int b = 0; b < 7; b++) begin
      for (int a = 0; a < 16; a++) begin
        mem[b][a] = 8'h00;
      end
    end
  end
  // Drive only while selected; a released bus shows a changing pattern
  always_comb begin
    data_in = ~last;
    for (int b = 0; b < 7; b++) begin
      if (!sel_n[b] && pins.rw_n) begin
        data_in = mem[b][pins.addr[3:0]];
      end
    end
  end
  // Write taken as the strobe rises, so late data is caught
  always @(negedge clock) begin
    last <= data_in;
    for (int b = 0; b < 7; b++) begin
      if (!prev_sel_n[b] && sel_n[b] && !pins.rw_n) begin
        mem[b][pins.addr[3:0]] <= pins.data_oe_n ? ~pins.data_out
                                                 : pins.data_out;
      end
    end
    prev_sel_n <= sel_n;
  end
endmodule

/* ecsb_controller_tb.sv */
// Self-checking bench for the chip-select bus controller
`timescale 1ns/100ps
module ecsb_controller_tb;
  import ecsb_pkg::*;
  typedef struct packed {
    logic        write;
    logic [2:0]  sel;
    logic [15:0] addr;
    logic [7:0]  data;
  } ecsb_row_s;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       microcomputer_mode = 1'b1;
  logic [5:0] select_output_en = 6'h00;
  logic       req_valid = 1'b0;
  ecsb_req_s  req = '0;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;
  logic [7:0] data_in;
  ecsb_pins_s pins;
  int         n_mismatch = 0;
  int         checks = 0;
  logic [6:0] prev_strobe_n = 7'h7F;
  logic [5:0] prev_oe_n = 6'h3F;
  logic [7:0] prev_data = 8'h00;
  logic [7:0] got;
  wire  [6:0] strobe_n = {pins.data_strobe_n, pins.select_n};
  // Same address in every bank: a stray strobe corrupts a neighbour
  ecsb_row_s  rows [14] = '{
    '{1'b1,3'h0,16'h2005,8'hA0}, '{1'b1,3'h1,16'h2005,8'hA1},
    '{1'b1,3'h2,16'h2005,8'hA2}, '{1'b1,3'h3,16'h2005,8'hA3},
    '{1'b1,3'h4,16'h2005,8'hA4}, '{1'b1,3'h5,16'h2005,8'hA5},
    '{1'b1,3'h7,16'h2005,8'hA7}, '{1'b0,3'h0,16'h2005,8'hA0},
    '{1'b0,3'h1,16'h2005,8'hA1}, '{1'b0,3'h2,16'h2005,8'hA2},
    '{1'b0,3'h3,16'h2005,8'hA3}, '{1'b0,3'h4,16'h2005,8'hA4},
    '{1'b0,3'h5,16'h2005,8'hA5}, '{1'b0,3'h7,16'h2005,8'hA7}};

  always #5 clock = ~clock;

  ecsb_controller uut (
    .clock              (clock),
    .reset              (reset),
    .microcomputer_mode (microcomputer_mode),
    .select_output_en   (select_output_en),
    .req_valid          (req_valid),
    .req                (req),
    .req_ready          (req_ready),
    .rsp_valid          (rsp_valid),
    .rsp_rdata          (rsp_rdata),
    .data_in            (data_in),
    .pins               (pins)
  );
  ecsb_memory_model model (
    .clock   (clock),
    .pins    (pins),
    .data_in (data_in)
  );

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One transfer, entered and left at a falling edge
  task automatic xfer(input ecsb_row_s r, output logic [7:0] rdata);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = ecsb_req_s'(r);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check(8'(n), 8'(ECSB_STROBE_CYC + ECSB_HOLD_CYC + 1));
    rdata = rsp_rdata;
    // The response pulse stands for one cycle only
    @(negedge clock);
    check({7'h00, rsp_valid}, 8'h00);
  endtask

  // Bus watch: single strobe, write hold, safe pin turn-on
  always @(negedge clock) begin
    if (!reset) begin
      check({7'h00, $countones(~strobe_n) > 1}, 8'h00);
      if (!pins.rw_n && prev_strobe_n != 7'h7F && strobe_n == 7'h7F) begin
        check({7'h00, pins.data_oe_n}, 8'h00);
        check(pins.data_out, prev_data);
      end
      check({2'h0, pins.select_n & prev_oe_n & ~pins.select_oe_n},
            {2'h0, prev_oe_n & ~pins.select_oe_n});
    end
    prev_strobe_n <= strobe_n;
    prev_oe_n <= pins.select_oe_n;
    prev_data <= pins.data_out;
  end

  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check({2'h0, pins.select_oe_n}, 8'h3F);
    check({1'h0, strobe_n}, 8'h7F);
    select_output_en = 6'h3F;
    repeat (3) @(negedge clock);
    foreach (rows[i]) begin
      xfer(rows[i], got);
      if (!rows[i].write) begin
        check(got, rows[i].data);
      end
    end
    // Bank request outside the mode falls back to the data strobe
    microcomputer_mode = 1'b0;
    repeat (3) @(negedge clock);
    check({2'h0, pins.select_oe_n}, 8'h3F);
    xfer('{1'b1, 3'h2, 16'h2009, 8'h5A}, got);
    xfer('{1'b0, 3'h7, 16'h2009, 8'h00}, got);
    check(got, 8'h5A);
    microcomputer_mode = 1'b1;
    repeat (3) @(negedge clock);
    xfer('{1'b0, 3'h2, 16'h2009, 8'h00}, got);
    check(got, 8'h00);
    // Second reset mid-run
    reset = 1'b1;
    repeat (2) @(negedge clock);
    check({2'h0, pins.select_oe_n}, 8'h3F);
    check({1'h0, strobe_n}, 8'h7F);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    xfer('{1'b0, 3'h7, 16'h2005, 8'h00}, got);
    check(got, 8'hA7);
    end_of_test();
  end
endmodule
